// ---- bench/lrc_crc_props.sv ----
`timescale 1ns/1ns
// ****
// port checks
// ****
module lrc_crc_props (
  input wire logic clock_i, rst_i, enable_i, frame_start_i, byte_valid_i, frame_end_i, tx_ready_i,
  input wire logic byte_ready_o, result_valid_o, tx_valid_o, check_done_o, check_error_o,
  input wire logic [7:0] lrc_o, tx_byte_o,
  input wire logic [15:0] crc_o
);
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_byte_eight_steps: assert property (
    enable_i && byte_ready_o && byte_valid_i && !frame_end_i && !frame_start_i |=>
    !byte_ready_o [*8] ##1 byte_ready_o)
    else $error("byte busy time wrong");
  a_end_gives_result: assert property (
    enable_i && byte_ready_o && frame_end_i && !frame_start_i |=> result_valid_o) else $error("no result");
  a_result_has_cause: assert property (
    result_valid_o |-> $past(frame_end_i) && $past(byte_ready_o) && $past(enable_i)) else $error("stray result");
  a_freeze_holds_state: assert property (
    !enable_i |=> $stable(byte_ready_o) && $stable(result_valid_o) && $stable(crc_o) && $stable(lrc_o))
    else $error("state moved while frozen");
  a_crc_holds: assert property (
    !result_valid_o |-> $stable(crc_o)) else $error("crc moved");
  a_lrc_holds: assert property (
    !result_valid_o |-> $stable(lrc_o)) else $error("lrc moved");
  a_tx_elem_holds: assert property (
    tx_valid_o && !tx_ready_i && !frame_start_i |=> tx_valid_o && $stable(tx_byte_o)) else $error("tx dropped");
  a_tx_first_elem: assert property (
    result_valid_o ##1 tx_valid_o |-> tx_byte_o == crc_o[7:0] || tx_byte_o == hx(lrc_o[7:4]))
    else $error("wrong first element");
  a_error_with_done: assert property (
    $rose(check_error_o) |-> check_done_o) else $error("error without done");
endmodule : lrc_crc_props
bind serial_frame_lrc_crc_check lrc_crc_props i_lrc_crc_props (.*);

// ---- bench/tb_serial_frame_lrc_crc_check.sv ----
`timescale 1ns/1ns
module tb_serial_frame_lrc_crc_check;
  logic clock_i = 0, rst_i = 1, enable_i = 1, frame_start_i = 0, mode_ascii_i = 0, tx_dir_i = 0;
  logic byte_valid_i = 0, frame_end_i = 0, check_valid_i = 0, tx_ready_i;
  logic byte_ready_o, result_valid_o, tx_valid_o, check_done_o, check_error_o;
  logic [7:0] byte_i = 0, check_byte_i = 0, lrc_o, tx_byte_o;
  logic [15:0] crc_o, got;
  int err_total = 0, compares = 0, cyc = 0, cnt, seed = 32'h8cd8e414;
  logic [7:0] q[$];
  serial_frame_lrc_crc_check i_serial_frame_lrc_crc_check (.*);
  tx_sink i_tx_sink (.clock_i, .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o), .tx_ready_o(tx_ready_i),
    .got_o(got), .cnt_o(cnt));
  initial forever #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      wrap_up;
    end
  end
  // ****
  // helpers
  // ****
  task automatic tick;
    @(posedge clock_i);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wait_rdy;
    for (int k = 0; k < 30 && byte_ready_o !== 1'b1; k++) tick;
  endtask : wait_rdy
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  function automatic logic [7:0] hx(input logic [3:0] n);
    return n < 4'ha ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  task automatic frame(input bit asc, input bit dir, input bit bad);
    logic [15:0] c;
    logic [7:0] s, e0, e1;
    int n;
    c = 16'hffff;
    s = 8'h00;
    frame_start_i = 1;
    mode_ascii_i = asc;
    tick;
    frame_start_i = 0;
    foreach (q[k]) begin
      s += q[k];
      c ^= {8'h00, q[k]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
      byte_valid_i = 1;
      byte_i = q[k];
      tick;
      if ($random(seed) & 1) tick; // second strobe cycle lands while busy and must be ignored
      byte_valid_i = 0;
      byte_i = $random(seed);
      wait_rdy;
    end
    s = ~s + 8'h01;
    tx_dir_i = dir;
    frame_end_i = 1;
    tick;
    frame_end_i = 0;
    chk("result_valid", result_valid_o, 16'h1);
    chk("lrc", lrc_o, s);
    chk("crc", crc_o, c);
    e0 = asc ? hx(s[7:4]) : c[7:0];
    e1 = asc ? hx(s[3:0]) : c[15:8];
    if (dir) begin
      n = cnt + 2;
      for (int k = 0; k < 40 && cnt < n; k++) tick;
      chk("tx field", got, {e0, e1});
    end else begin
      check_valid_i = 1;
      check_byte_i = e0;
      tick;
      check_byte_i = bad ? e1 ^ 8'h01 : e1;
      tick;
      check_valid_i = 0;
      chk("done", check_done_o, 16'h1);
      chk("error", check_error_o, {15'h0, bad});
    end
    wait_rdy;
    $display("frame done");
  endtask : frame
  initial begin
    repeat (12) tick;
    rst_i = 0;
    chk("reset crc", crc_o, 16'hffff);
    chk("reset ready", byte_ready_o, 16'h1);
    q = '{8'h02, 8'h07};
    frame(0, 1, 0);
    chk("example crc", crc_o, 16'h1241);
    q = '{8'hff, 8'hff, 8'h03};
    frame(1, 1, 0);
    chk("wrapped lrc", lrc_o, 16'hff);
    q = '{8'h3a, 8'h0d, 8'h0a};
    frame(1, 0, 1);
    // frozen clock enable must swallow a frame end
    enable_i = 0;
    frame_end_i = 1;
    tick;
    frame_end_i = 0;
    enable_i = 1;
    chk("frozen result", result_valid_o, 16'h0);
    chk("frozen ready", byte_ready_o, 16'h1);
    chk("frozen error", check_error_o, 16'h1);
    $display("freeze done");
    for (int t = 0; t < 12; t++) begin
      q.delete();
      repeat (1 + $unsigned($random(seed)) % 6) q.push_back($random(seed));
      frame($random(seed), $random(seed), $random(seed));
    end
    rst_i = 1;
    repeat (2) tick;
    rst_i = 0;
    chk("second reset crc", crc_o, 16'hffff);
    wrap_up;
  end
endmodule : tb_serial_frame_lrc_crc_check

// ---- bench/tx_sink.sv ----
`timescale 1ns/1ns
module tx_sink (
  input wire logic clock_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic tx_ready_o,
  output logic [15:0] got_o,
  output int cnt_o
);
  int seed = 32'h5a17;
  initial begin
    tx_ready_o = 0;
    got_o = 0;
    cnt_o = 0;
  end
  // stalls about a third of cycles, so held elements get exercised
  always @(posedge clock_i) begin
    if (tx_valid_i && tx_ready_o) begin
      got_o <= {got_o[7:0], tx_byte_i};
      cnt_o <= cnt_o + 1;
    end
    #1 tx_ready_o = $random(seed) % 3 != 0;
  end
endmodule : tx_sink

// ---- src/crc16_step.sv ----
`timescale 1ns/1ns
module crc16_step (
  input wire logic [15:0] crc_i,
  output logic [15:0] crc_o
);
  import lrc_crc_pkg::*;

  // ************************************************************
  // one shift and conditional xor
  // ************************************************************
  always_comb begin
    crc_o = {1'b0, crc_i[15:1]};
    if (crc_i[0]) begin
      crc_o = crc_o ^ CRC_POLY;
    end
  end

endmodule : crc16_step

// ---- src/lrc_crc_pkg.sv ----
// Overview of operation
// - longitudinal check is one 8-bit byte
// - transmit: compute check, append after covered bytes
// - receive: recompute, compare, flag mismatch
// - 8-bit sum, carries dropped, wraps through zero
// - colon and CR/LF never enter the sum (not filtered here: every accepted byte_i is summed)
// - final check is all-ones minus sum, plus one
// - two ASCII characters, high nibble first
// - cyclic check is one 16-bit two-byte value
// - receive: recompute cyclic check, flag mismatch
// - cyclic register preset to all ones per frame
// - only the eight data bits enter
// - byte XORed into low register byte first
// - shift right, zero fill, XOR fixed value on one
// - exactly eight steps per byte
// - final register is the value, no inversion
// - cyclic check sent low byte first
package lrc_crc_pkg;

  // ************************************************************
  // check constants
  // ************************************************************
  localparam logic [15:0] CRC_PRESET = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [7:0] LRC_PRESET = 8'h00;
  localparam logic [7:0] LRC_ALL_ONES = 8'hff;
  localparam logic [7:0] LRC_ONE = 8'h01;
  localparam logic [2:0] SHIFT_FIRST = 3'h0;
  localparam logic [2:0] SHIFT_LAST = 3'h7;

  // ************************************************************
  // hex character coding
  // ************************************************************
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [7:0] ASCII_UPPER_A = 8'h41;
  localparam logic [7:0] ASCII_UPPER_F = 8'h46;
  localparam logic [7:0] ASCII_LETTER_BASE = 8'h37;
  localparam logic [3:0] NIBBLE_TEN = 4'ha;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SHIFT = 3'b001,
    ST_SEND  = 3'b010,
    ST_RECV  = 3'b011
  } state_t;

  function automatic logic [7:0] hex_encode(input logic [3:0] nib);
    if (nib < NIBBLE_TEN) begin
      hex_encode = ASCII_ZERO + {4'h0, nib};
    end else begin
      hex_encode = ASCII_LETTER_BASE + {4'h0, nib};
    end
  endfunction : hex_encode

  function automatic logic hex_valid(input logic [7:0] ch);
    hex_valid = ((ch >= ASCII_ZERO) && (ch <= ASCII_NINE)) ||
                ((ch >= ASCII_UPPER_A) && (ch <= ASCII_UPPER_F));
  endfunction : hex_valid

  function automatic logic [3:0] hex_decode(input logic [7:0] ch);
    logic [7:0] v;
    v = (ch <= ASCII_NINE) ? (ch - ASCII_ZERO) : (ch - ASCII_LETTER_BASE);
    hex_decode = v[3:0];
  endfunction : hex_decode

endpackage : lrc_crc_pkg

// ---- src/serial_frame_lrc_crc_check.sv ----
`timescale 1ns/1ns
module serial_frame_lrc_crc_check (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic frame_start_i,
  input wire logic mode_ascii_i,
  input wire logic tx_dir_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic frame_end_i,
  input wire logic tx_ready_i,
  input wire logic check_valid_i,
  input wire logic [7:0] check_byte_i,
  output logic byte_ready_o,
  output logic result_valid_o,
  output logic [7:0] lrc_o,
  output logic [15:0] crc_o,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  output logic check_done_o,
  output logic check_error_o
);
  import lrc_crc_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    lrc_crc_pkg::state_t state;
    logic ascii;
    logic [7:0] sum;
    logic [15:0] crc;
    logic [2:0] count;
    logic [7:0] lrc;
    logic [15:0] crc_res;
    logic idx;
    logic [7:0] rx_first;
    logic ready;
    logic result_valid;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic check_done;
    logic check_error;
  } regs_t;

  localparam regs_t REGS_RESET = '{
    state: ST_IDLE,
    ascii: 1'b0,
    sum: LRC_PRESET,
    crc: CRC_PRESET,
    count: SHIFT_FIRST,
    lrc: LRC_PRESET,
    crc_res: CRC_PRESET,
    idx: 1'b0,
    rx_first: 8'h00,
    ready: 1'b1,
    result_valid: 1'b0,
    tx_valid: 1'b0,
    tx_byte: 8'h00,
    check_done: 1'b0,
    check_error: 1'b0
  };

  regs_t q;
  regs_t d;
  logic [15:0] step_crc;
  logic [7:0] send_char;
  logic rx_mismatch;

  crc16_step u_step (
    .crc_i(q.crc),
    .crc_o(step_crc)
  );

  // ************************************************************
  // check field selection
  // ************************************************************
  always_comb begin
    send_char = 8'h00;
    rx_mismatch = 1'b0;
    if (q.ascii) begin
      send_char = q.idx ? hex_encode(q.lrc[3:0]) : hex_encode(q.lrc[7:4]);
      rx_mismatch = !hex_valid(q.rx_first) || !hex_valid(check_byte_i) ||
                    ({hex_decode(q.rx_first), hex_decode(check_byte_i)} != q.lrc);
    end else begin
      send_char = q.idx ? q.crc_res[15:8] : q.crc_res[7:0];
      rx_mismatch = {check_byte_i, q.rx_first} != q.crc_res;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    d.result_valid = 1'b0;
    d.check_done = 1'b0;
    // data held until the partner takes it
    if (q.tx_valid && tx_ready_i) begin
      d.tx_valid = 1'b0;
    end
    unique case (q.state)
      ST_IDLE: begin
        if (frame_end_i) begin
          d.lrc = (LRC_ALL_ONES - q.sum) + LRC_ONE;
          d.crc_res = q.crc;
          d.result_valid = 1'b1;
          d.idx = 1'b0;
          d.check_error = 1'b0;
          d.state = tx_dir_i ? ST_SEND : ST_RECV;
        end else if (byte_valid_i) begin
          // partner strips the colon and line end before this port
          d.sum = q.sum + byte_i;
          d.crc = q.crc ^ {8'h00, byte_i};
          d.count = SHIFT_FIRST;
          d.state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        d.crc = step_crc;
        d.count = q.count + 3'h1;
        if (q.count == SHIFT_LAST) begin
          d.state = ST_IDLE;
        end
      end
      ST_SEND: begin
        if (!q.tx_valid || tx_ready_i) begin
          d.tx_valid = 1'b1;
          d.tx_byte = send_char;
          d.idx = ~q.idx;
          if (q.idx) begin
            d.state = ST_IDLE;
          end
        end
      end
      ST_RECV: begin
        if (check_valid_i) begin
          if (!q.idx) begin
            d.rx_first = check_byte_i;
            d.idx = 1'b1;
          end else begin
            d.check_done = 1'b1;
            d.check_error = rx_mismatch;
            d.idx = 1'b0;
            d.state = ST_IDLE;
          end
        end
      end
      default: begin
        d.state = ST_IDLE;
      end
    endcase
    // frame start overrides state, sums, index and pending tx byte; a same-cycle result pulse still goes out
    if (frame_start_i) begin
      d.sum = LRC_PRESET;
      d.crc = CRC_PRESET;
      d.ascii = mode_ascii_i;
      d.idx = 1'b0;
      d.tx_valid = 1'b0;
      d.check_error = 1'b0;
      d.state = ST_IDLE;
    end
    d.ready = (d.state == ST_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      q <= REGS_RESET;
    end else if (enable_i) begin
      q <= d;
    end
  end

  assign byte_ready_o = q.ready;
  assign result_valid_o = q.result_valid;
  assign lrc_o = q.lrc;
  assign crc_o = q.crc_res;
  assign tx_valid_o = q.tx_valid;
  assign tx_byte_o = q.tx_byte;
  assign check_done_o = q.check_done;
  assign check_error_o = q.check_error;

endmodule : serial_frame_lrc_crc_check
